/* File: ufc_pkg.sv */
// constants for the uart frame and handshake configuration block
package ufc_pkg;
    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam logic [15:0] CFG_IDX = 16'h44ae;
    localparam logic [15:0] STAT_IDX = 16'h4500;
    localparam logic [15:0] TXD_IDX = 16'h4501;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int CFG_W = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
    localparam int B_RTS = 0;
    localparam int B_8BIT = 1;
    localparam int B_2STP = 2;
    localparam int B_PAR = 3;
    localparam int B_ODD = 4;
    localparam int B_FLOW = 5;
    localparam int B_AUTO = 6;
    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int S_CTS = 0;
    localparam int S_BUSY = 1;
    localparam int S_PEND = 2;
    localparam int S_RTS = 3;
    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125000000;
    localparam int BAUD = 115200;
    localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD);
    localparam int FRAME_W = 12;
    localparam logic [3:0] LEN_BASE = 4'h9;
    typedef enum logic [1:0] {
        UFC_IDLE = 2'b01,
        UFC_SHIFT = 2'b10
    } ufc_tx_state_t;
endpackage

/* File: ufc_tx.sv */
// serial character transmitter with configurable frame
`timescale 1ns/1ns
module ufc_tx
    import ufc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic eight_bit_select,
    input wire logic parity_enable,
    input wire logic odd_parity_select,
    input wire logic two_stop_select,
    output logic txd,
    output logic busy
);
    ufc_tx_state_t state;
    logic [FRAME_W-1:0] sr;
    logic [3:0] len;
    logic [3:0] cnt;
    logic [15:0] baud;
    // ------------------------------------------------------------
    // frame assembly
    // ------------------------------------------------------------
    wire [7:0] dbits = eight_bit_select ? data : {1'b0, data[6:0]};
    wire par_bit = parity_enable ? (^dbits ^ odd_parity_select) : 1'b1;
    wire [FRAME_W-1:0] frame8 = {2'h3, par_bit, data, 1'b0};
    wire [FRAME_W-1:0] frame7 = {3'h7, par_bit, data[6:0], 1'b0};
    wire [3:0] next_len = LEN_BASE + {3'h0, eight_bit_select} + {3'h0, parity_enable}
        + {3'h0, two_stop_select};
    wire baud_end = (baud == BAUD_DIV - 16'h1);
    wire go = start && (state == UFC_IDLE);
    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= UFC_IDLE;
            sr <= '1;
            len <= 4'h0;
            cnt <= 4'h0;
            baud <= 16'h0;
            txd <= 1'b1;
            busy <= 1'b0;
        end else begin
            case (state)
                UFC_IDLE: begin
                    txd <= 1'b1;
                    if (go) begin
                        sr <= eight_bit_select ? frame8 : frame7;
                        len <= next_len;
                        cnt <= 4'h0;
                        baud <= 16'h0;
                        busy <= 1'b1;
                        state <= UFC_SHIFT;
                    end
                end
                UFC_SHIFT: begin
                    txd <= sr[0];
                    baud <= baud_end ? 16'h0 : baud + 16'h1;
                    if (baud_end) begin
                        sr <= {1'b1, sr[FRAME_W-1:1]};
                        cnt <= cnt + 4'h1;
                        if (cnt == len - 4'h1) begin
                            busy <= 1'b0;
                            state <= UFC_IDLE;
                        end
                    end
                end
                default: state <= UFC_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_odd_par;
        @(posedge sys_clk) disable iff (sys_rst)
        go && parity_enable && eight_bit_select |=> sr[9] == (^$past(data) ^ $past(odd_parity_select));
    endproperty
    a_odd_par: assert property (p_odd_par) else $error("parity sense wrong");
    property p_par_len;
        @(posedge sys_clk) disable iff (sys_rst)
        go |=> len == 4'h9 + {3'h0, $past(eight_bit_select)} + {3'h0, $past(parity_enable)}
            + {3'h0, $past(two_stop_select)};
    endproperty
    a_par_len: assert property (p_par_len) else $error("frame length wrong");
    property p_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        go && !eight_bit_select && !parity_enable |=> sr[8] && sr[9] && sr[10];
    endproperty
    a_stop: assert property (p_stop) else $error("stop bits missing");
    property p_seven;
        @(posedge sys_clk) disable iff (sys_rst)
        go && !eight_bit_select |=> sr[7:0] == {$past(data[6:0]), 1'b0};
    endproperty
    a_seven: assert property (p_seven) else $error("seven bit frame wrong");
    c_frame: cover property (@(posedge sys_clk) disable iff (sys_rst) busy ##1 !busy);
endmodule

/* File: ufc_top.sv */
// uart frame and handshake configuration with axi4-lite registers
`timescale 1ns/1ns
module ufc_top
    import ufc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic clear_to_send_in_n,
    input wire logic rx_nearly_full,
    output logic request_to_send_out_n,
    output logic txd
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CFG_W-1:0] uart_frame_config;
    logic [7:0] tx_byte;
    logic tx_pend;
    logic tx_busy;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire handshake_enable = uart_frame_config[B_FLOW];
    wire auto_rts_enable = uart_frame_config[B_AUTO];
    wire manual_flow_request_level = uart_frame_config[B_RTS];
    wire cts_ok = !handshake_enable || !clear_to_send_in_n;
    wire launch = tx_pend && !tx_busy && cts_ok;
    wire next_rts_n = !handshake_enable ? 1'b1
        : auto_rts_enable ? rx_nearly_full
        : !manual_flow_request_level;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire do_wr = aw_got && w_got && !s_axi_bvalid;
    wire [15:0] wr_idx = aw_addr[ADDR_W-1:2];
    wire [15:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
    wire wr_cfg = do_wr && (wr_idx == CFG_IDX) && w_strb[0];
    wire wr_txd = do_wr && (wr_idx == TXD_IDX) && w_strb[0];
    wire wr_hit = (wr_idx == CFG_IDX) || (wr_idx == STAT_IDX) || (wr_idx == TXD_IDX);
    wire rd_hit = (rd_idx == CFG_IDX) || (rd_idx == STAT_IDX) || (rd_idx == TXD_IDX);
    wire [31:0] stat_word = {28'h0, !request_to_send_out_n, tx_pend, tx_busy, cts_ok};
    wire [31:0] rd_word = (rd_idx == CFG_IDX) ? {25'h0, uart_frame_config}
        : (rd_idx == STAT_IDX) ? stat_word
        : (rd_idx == TXD_IDX) ? {24'h0, tx_byte}
        : 32'h0;
    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            uart_frame_config <= CFG_RST;
        end else if (wr_cfg) begin
            uart_frame_config <= w_data[CFG_W-1:0];
        end
    end
    // a new byte written while one waits replaces it; the write wins over the launch
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_byte <= 8'h00;
            tx_pend <= 1'b0;
        end else if (wr_txd) begin
            tx_byte <= w_data[7:0];
            tx_pend <= 1'b1;
        end else if (launch) begin
            tx_pend <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // flow control output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            request_to_send_out_n <= 1'b1;
        end else begin
            request_to_send_out_n <= next_rts_n;
        end
    end
    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    ufc_tx u_tx (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(launch),
        .data(tx_byte),
        .eight_bit_select(uart_frame_config[B_8BIT]),
        .parity_enable(uart_frame_config[B_PAR]),
        .odd_parity_select(uart_frame_config[B_ODD]),
        .two_stop_select(uart_frame_config[B_2STP]),
        .txd(txd),
        .busy(tx_busy)
    );
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_flow_off;
        @(posedge sys_clk) disable iff (sys_rst)
        !handshake_enable |=> request_to_send_out_n;
    endproperty
    a_flow_off: assert property (p_flow_off) else $error("rts active with handshake off");
    property p_cts_forced;
        @(posedge sys_clk) disable iff (sys_rst)
        !handshake_enable && tx_pend && !tx_busy && !wr_txd |=> tx_busy && !tx_pend;
    endproperty
    a_cts_forced: assert property (p_cts_forced) else $error("send blocked with handshake off");
    property p_rts_set;
        @(posedge sys_clk) disable iff (sys_rst)
        handshake_enable && !auto_rts_enable && manual_flow_request_level |=> !request_to_send_out_n;
    endproperty
    a_rts_set: assert property (p_rts_set) else $error("rts not driven low");
    property p_rts_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        handshake_enable && !auto_rts_enable && !manual_flow_request_level |=> request_to_send_out_n;
    endproperty
    a_rts_clr: assert property (p_rts_clr) else $error("rts not driven high");
    property p_auto;
        @(posedge sys_clk) disable iff (sys_rst)
        handshake_enable && auto_rts_enable |=> request_to_send_out_n == $past(rx_nearly_full);
    endproperty
    a_auto: assert property (p_auto) else $error("auto rts not followed");
    property p_cts_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        handshake_enable && clear_to_send_in_n && !tx_busy |=> !tx_busy;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("char started without cts");
    property p_bresp;
        @(posedge sys_clk) disable iff (sys_rst)
        do_wr |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response dropped");
    // ------------------------------------------------------------
    // bus and transmit checks
    // ------------------------------------------------------------
    property p_wr_ok;
        @(posedge sys_clk) disable iff (sys_rst)
        do_wr && wr_hit |=> s_axi_bresp == RESP_OKAY;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("mapped write refused");
    property p_wr_err;
        @(posedge sys_clk) disable iff (sys_rst)
        do_wr && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
    property p_b_wait;
        @(posedge sys_clk) disable iff (sys_rst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_wait: assert property (p_b_wait) else $error("write taken while response waits");
    property p_b_done;
        @(posedge sys_clk) disable iff (sys_rst)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write channel not freed");
    property p_aw_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        aw_got |-> !s_axi_awready;
    endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("second write address taken");
    property p_w_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        w_got |-> !s_axi_wready;
    endproperty
    a_w_hold: assert property (p_w_hold) else $error("second write data taken");
    property p_ar_answer;
        @(posedge sys_clk) disable iff (sys_rst)
        ar_fire |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
    property p_rd_ok;
        @(posedge sys_clk) disable iff (sys_rst)
        ar_fire && rd_hit |=> s_axi_rresp == RESP_OKAY;
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
    property p_rd_err;
        @(posedge sys_clk) disable iff (sys_rst)
        ar_fire && !rd_hit |=> s_axi_rresp == RESP_SLVERR;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_r_done;
        @(posedge sys_clk) disable iff (sys_rst)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read channel not freed");
    property p_rd_upper;
        @(posedge sys_clk) disable iff (sys_rst)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    property p_cfg_load;
        @(posedge sys_clk) disable iff (sys_rst)
        wr_cfg |=> uart_frame_config == $past(w_data[CFG_W-1:0]);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config write lost");
    property p_cfg_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        !wr_cfg |=> $stable(uart_frame_config);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");
    property p_pend_set;
        @(posedge sys_clk) disable iff (sys_rst)
        wr_txd |=> tx_pend;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("written byte not pending");
    property p_launch;
        @(posedge sys_clk) disable iff (sys_rst)
        launch |=> tx_busy;
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start transmitter");
    property p_cts_wait;
        @(posedge sys_clk) disable iff (sys_rst)
        handshake_enable && clear_to_send_in_n && tx_pend |=> tx_pend;
    endproperty
    a_cts_wait: assert property (p_cts_wait) else $error("pending byte lost without cts");
    property p_txd_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        !tx_busy |=> txd;
    endproperty
    a_txd_idle: assert property (p_txd_idle) else $error("line not idle high");
    c_flow: cover property (@(posedge sys_clk) disable iff (sys_rst) handshake_enable && launch);
    c_block: cover property (@(posedge sys_clk) disable iff (sys_rst)
        (handshake_enable && tx_pend && clear_to_send_in_n) [*3] ##1 launch);
    c_slverr: cover property (@(posedge sys_clk) disable iff (sys_rst) s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_auto: cover property (@(posedge sys_clk) disable iff (sys_rst)
        auto_rts_enable && handshake_enable && $rose(request_to_send_out_n));
endmodule

/* File: ufc_peer.sv */
// serial peer model: receives frames, drives clear-to-send
`timescale 1ns/1ns
module ufc_peer
    import ufc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic txd,
    input wire logic request_to_send_out_n,
    input wire logic hold,
    input wire logic [3:0] fmt,
    output logic clear_to_send_in_n,
    output logic may_send,
    output logic [7:0] rx_data,
    output logic rx_par,
    output logic [1:0] rx_stop,
    output logic [7:0] rx_cnt
);
    assign clear_to_send_in_n = hold;
    // peer only sends while request-to-send is low
    assign may_send = !request_to_send_out_n;
    task automatic bit_wait(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // fmt is {odd, parity, two stop, eight bit}
    initial begin
        rx_cnt = 8'h00;
        rx_data = 8'h00;
        rx_par = 1'b0;
        rx_stop = 2'h0;
        forever begin
            @(negedge txd);
            bit_wait(int'(BAUD_DIV) / 2);
            rx_data = 8'h00;
            for (int i = 0; i < (fmt[0] ? 8 : 7); i++) begin
                bit_wait(int'(BAUD_DIV));
                rx_data[i] = txd;
            end
            if (fmt[2]) begin
                bit_wait(int'(BAUD_DIV));
                rx_par = txd;
            end
            bit_wait(int'(BAUD_DIV));
            rx_stop = {1'b1, txd};
            if (fmt[1]) begin
                bit_wait(int'(BAUD_DIV));
                rx_stop[1] = txd;
            end
            rx_cnt = rx_cnt + 8'h01;
        end
    end
endmodule

/* File: testbench.sv */
// self-checking bench for the uart frame configuration block
`timescale 1ns/1ns
module testbench
    import ufc_pkg::*;
();
    localparam logic [ADDR_W-1:0] A_CFG = {CFG_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_TXD = {TXD_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_BAD = 18'h00100;
    localparam logic [6:0] CORNER [0:5] = '{7'h21, 7'h20, 7'h01, 7'h61, 7'h60, 7'h41};
    localparam logic [6:0] FMT [0:3] = '{7'h02, 7'h0c, 7'h1a, 7'h14};
    logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic clear_to_send_in_n, rx_nearly_full, request_to_send_out_n, txd, hold, may_send, rx_par;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rx_stop;
    logic [7:0] rx_data, rx_cnt, c0, d;
    logic [6:0] cfg;
    int err_count, n_checks;
    ufc_top u_ufc_top (
        .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .clear_to_send_in_n, .rx_nearly_full,
        .request_to_send_out_n, .txd
    );
    ufc_peer u_ufc_peer (
        .sys_clk, .txd, .request_to_send_out_n, .hold, .fmt(cfg[4:1]), .clear_to_send_in_n,
        .may_send, .rx_data, .rx_par, .rx_stop, .rx_cnt
    );
    function automatic logic exp_rts_n(logic [6:0] c, logic nf);
        return c[B_FLOW] ? (c[B_AUTO] ? nf : !c[B_RTS]) : 1'b1;
    endfunction
    function automatic logic [7:0] exp_data(logic [6:0] c, logic [7:0] v);
        return c[B_8BIT] ? v : {1'b0, v[6:0]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && t < 99);
        s_axi_bready <= 1'b0;
        check("bresp", {s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    endtask
    task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] v, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && t < 99);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check("rresp", {s_axi_rvalid, s_axi_rresp}, {1'b1, er});
    endtask
    task automatic frame_go(input logic [6:0] c, input logic [7:0] v);
        cfg = c;
        d = v;
        axw(A_CFG, {25'h0, c}, RESP_OKAY);
        c0 = rx_cnt;
        axw(A_TXD, {24'h0, v}, RESP_OKAY);
    endtask
    task automatic frame_check();
        int t;
        t = 0;
        while (rx_cnt === c0 && t < 20000) begin
            @(posedge sys_clk);
            t++;
        end
        check("rx_data", rx_data, exp_data(cfg, d));
        if (cfg[B_PAR]) check("rx_par", rx_par, ^exp_data(cfg, d) ^ cfg[B_ODD]);
        check("rx_stop", rx_stop, 2'h3);
        axr(A_STAT, rd, RESP_OKAY);
        check("busy_end", rd[S_BUSY], 1'b1);
        repeat (int'(BAUD_DIV)) @(posedge sys_clk);
        axr(A_STAT, rd, RESP_OKAY);
        check("busy_end", rd[S_BUSY], 1'b0);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #800000;
        err_count++;
        final_report();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hee79));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        sys_rst = 1'b1;
        s_axi_awaddr = A_CFG;
        s_axi_araddr = A_CFG;
        s_axi_wdata = 32'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hf;
        rx_nearly_full = 1'b0;
        hold = 1'b1;
        cfg = 7'h00;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check("rts_n", request_to_send_out_n, 1'b1);
        check("txd", txd, 1'b1);
        axr(A_CFG, rd, RESP_OKAY);
        check("cfg_rst", rd, 32'h0);
        // pin mux choice is left to software outside this block
        for (int i = 0; i < 28; i++) begin
            cfg = (i < 6) ? CORNER[i] : 7'($urandom);
            rx_nearly_full <= i[0] ^ 1'($urandom);
            axw(A_CFG, {25'h0, cfg}, RESP_OKAY);
            axr(A_CFG, rd, RESP_OKAY);
            check("cfg", rd, {25'h0, cfg});
            check("rts_n", request_to_send_out_n, exp_rts_n(cfg, rx_nearly_full));
            axr(A_STAT, rd, RESP_OKAY);
            check("stat_rts", rd[S_RTS], !exp_rts_n(cfg, rx_nearly_full));
            check("may_send", may_send, !exp_rts_n(cfg, rx_nearly_full));
        end
        axw(A_BAD, 32'h7f, RESP_SLVERR);
        axr(A_BAD, rd, RESP_SLVERR);
        axr(A_CFG, rd, RESP_OKAY);
        check("cfg_keep", rd, {25'h0, cfg});
        s_axi_wstrb <= 4'he;
        axw(A_CFG, {25'h0, ~cfg}, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axr(A_CFG, rd, RESP_OKAY);
        check("cfg_strb", rd, {25'h0, cfg});
        // clear-to-send held off while handshake is disabled
        for (int i = 0; i < 4; i++) begin
            frame_go(FMT[i], 8'($urandom));
            frame_check();
        end
        frame_go(7'h22, 8'($urandom));
        repeat (2000) @(posedge sys_clk);
        axr(A_STAT, rd, RESP_OKAY);
        check("held", {rx_cnt, txd, rd[2:0]}, {c0, 1'b1, 3'h4});
        hold <= 1'b0;
        repeat (3000) @(posedge sys_clk);
        hold <= 1'b1;
        frame_check();
        final_report();
    end
endmodule
